/* design/tpc_fifo.sv */
// Sample FIFO between segment fetch and the DAC side.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/10ps
`include "tpc_regs.svh"

module tpc_fifo
   import tpc_pkg::*;
#(
   parameter int W = `TPC_DAC_W,
   parameter int DEPTH = `TPC_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
   logic [AW:0] cnt_ff, nxt_cnt;
   logic push, pop;

   // Handshakes and next pointers
   always_comb begin
      in_ready = (cnt_ff != DEPTH[AW:0]);
      out_valid = (cnt_ff != '0);
      out_data = mem[rp_ff];
      level = cnt_ff;
      push = in_valid & in_ready & ~flush;
      pop = out_valid & out_ready & ~flush;
      nxt_wp = wp_ff + AW'(push);
      nxt_rp = rp_ff + AW'(pop);
      nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      if (flush) begin
         nxt_wp = '0;
         nxt_rp = '0;
         nxt_cnt = '0;
      end
   end

   // Pointer registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
      end else if (ce) begin
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         cnt_ff <= nxt_cnt;
      end
   end

   // Storage
   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[wp_ff] <= in_data;
      end
   end
endmodule

/* design/tpc_pkg.sv */
// Types shared by the trigger playback control block.
// Assumes tpc_regs.svh is on the include path.
`include "tpc_regs.svh"

package tpc_pkg;

   typedef enum {ST_PRIME, ST_CAPT, ST_WAIT, ST_PLAY} tpc_state_t;

   typedef enum logic [1:0] {IDLE_DC, IDLE_FIRST, IDLE_SEG} tpc_idle_t;

   typedef struct packed {
      logic run;
      logic abort_now;
      tpc_idle_t idle;
      logic low_jitter_mode;
      logic [2:0] start_sel;
      logic [2:0] abort_sel;
      logic [`TPC_NSRC-1:0] trig_en;
      logic [`TPC_DAC_W-1:0] dc_level;
      logic [`TPC_LOOP_W-1:0] loops;
      logic [`TPC_ADDR_W-1:0] seg_len;
   } tpc_cfg_t;

endpackage

/* design/tpc_play_ctrl.sv */
// Trigger-mode playback control of one waveform channel: register
// file on AHB-Lite, segment fetch, idle output and loop counting.
// Assumes segment memory answers a read one cycle after seg_rd_en
// and the DAC side takes a sample whenever dac_ready is high.
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "tpc_regs.svh"

module tpc_play_ctrl
   import tpc_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [4:0] trig_ext,
   output logic seg_rd_en,
   output logic [`TPC_ADDR_W-1:0] seg_addr,
   input wire logic [`TPC_DAC_W-1:0] seg_data,
   input wire logic dac_ready,
   output logic [`TPC_DAC_W-1:0] dac_data
);
   // Register file state
   tpc_cfg_t cfg_ff, nxt_cfg;
   logic [7:0] dp_addr_ff, nxt_dp_addr;
   logic dp_wr_ff, nxt_dp_wr;
   logic [31:0] rdata_ff, nxt_rdata;
   logic bus_trig, seg_chg;

   // Playback state
   tpc_state_t state_ff, nxt_state;
   logic [`TPC_ADDR_W-1:0] addr_ff, nxt_addr, seg_last;
   logic [`TPC_LOOP_W-1:0] loop_ff, nxt_loop;
   logic pend_ff, nxt_pend, pkind_ff, nxt_pkind;
   logic [`TPC_DAC_W-1:0] first_ff, nxt_first;
   logic rdp_ff, nxt_rdp;
   logic [`TPC_DAC_W-1:0] dac_ff, nxt_dac;
   logic flush, fetch_ok, start_pulse, abort_pulse;

   // FIFO ports
   logic fifo_in_ready, fifo_ov;
   logic [`TPC_DAC_W-1:0] fifo_data;
   logic [`TPC_LVL_W-1:0] fifo_level;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_ff;
   assign seg_addr = addr_ff;
   assign dac_data = dac_ff;

   // Bus slave: latch address phase, apply write in data phase,
   // prepare read data from the config values the next edge will hold
   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_dp_addr = dp_addr_ff;
      nxt_dp_wr = 1'b0;
      nxt_rdata = rdata_ff;
      bus_trig = 1'b0;
      seg_chg = 1'b0;
      if (dp_wr_ff) begin
         unique case (dp_addr_ff)
            `TPC_OFF_CTRL: begin
               nxt_cfg.run = hwdata[`TPC_CTRL_RUN];
               nxt_cfg.abort_now = hwdata[`TPC_CTRL_NOW];
               nxt_cfg.idle = tpc_idle_t'(hwdata[`TPC_CTRL_IDLE_LO +: 2]);
               nxt_cfg.low_jitter_mode = hwdata[`TPC_CTRL_LJ];
               bus_trig = hwdata[`TPC_CTRL_BUSTRIG];
            end
            `TPC_OFF_SRC: begin
               nxt_cfg.start_sel = hwdata[`TPC_SRC_START_LO +: 3];
               nxt_cfg.abort_sel = hwdata[`TPC_SRC_ABORT_LO +: 3];
               nxt_cfg.trig_en = hwdata[`TPC_SRC_EN_LO +: `TPC_NSRC];
            end
            `TPC_OFF_DC: nxt_cfg.dc_level = hwdata[`TPC_DAC_W-1:0];
            `TPC_OFF_LOOPS: nxt_cfg.loops = hwdata[`TPC_LOOP_W-1:0];
            `TPC_OFF_SEGLEN: begin
               nxt_cfg.seg_len = hwdata[`TPC_ADDR_W-1:0];
               seg_chg = 1'b1;
            end
            default: ;
         endcase
      end
      if (hsel && htrans[1] && hready) begin
         nxt_dp_addr = haddr[7:0];
         nxt_dp_wr = hwrite;
         nxt_rdata = 32'h00000000;
         if (!hwrite) begin
            unique case (haddr[7:0])
               `TPC_OFF_CTRL: begin
                  nxt_rdata[`TPC_CTRL_RUN] = nxt_cfg.run;
                  nxt_rdata[`TPC_CTRL_NOW] = nxt_cfg.abort_now;
                  nxt_rdata[`TPC_CTRL_IDLE_LO +: 2] = nxt_cfg.idle;
                  nxt_rdata[`TPC_CTRL_LJ] = nxt_cfg.low_jitter_mode;
               end
               `TPC_OFF_SRC: begin
                  nxt_rdata[`TPC_SRC_START_LO +: 3] = nxt_cfg.start_sel;
                  nxt_rdata[`TPC_SRC_ABORT_LO +: 3] = nxt_cfg.abort_sel;
                  nxt_rdata[`TPC_SRC_EN_LO +: `TPC_NSRC] = nxt_cfg.trig_en;
               end
               `TPC_OFF_DC: nxt_rdata[`TPC_DAC_W-1:0] = nxt_cfg.dc_level;
               `TPC_OFF_LOOPS: nxt_rdata[`TPC_LOOP_W-1:0] = nxt_cfg.loops;
               `TPC_OFF_SEGLEN: nxt_rdata[`TPC_ADDR_W-1:0] = nxt_cfg.seg_len;
               `TPC_OFF_STATUS: begin
                  nxt_rdata[`TPC_STAT_STATE_LO +: 2] = 2'(state_ff);
                  nxt_rdata[`TPC_STAT_PEND] = pend_ff;
                  nxt_rdata[`TPC_STAT_EMPTY] = ~fifo_ov;
                  nxt_rdata[`TPC_STAT_LOOP_LO +: `TPC_LOOP_W] = loop_ff;
               end
               default: ;
            endcase
         end
      end
   end

   // Bus slave registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_ff <= '{run: 1'b0, abort_now: 1'b0, idle: IDLE_DC,
                     low_jitter_mode: 1'b0, start_sel: 3'h0,
                     abort_sel: 3'h0, trig_en: 6'h00,
                     dc_level: `TPC_RST_DC, loops: `TPC_RST_LOOPS,
                     seg_len: `TPC_RST_SEGLEN};
         dp_addr_ff <= 8'h00;
         dp_wr_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
      end else if (ce) begin
         cfg_ff <= nxt_cfg;
         dp_addr_ff <= nxt_dp_addr;
         dp_wr_ff <= nxt_dp_wr;
         rdata_ff <= nxt_rdata;
      end
   end

   // Source order: ext1, ext2, bus, internal, digitizer, jump connector
   tpc_trig_qual u_qual (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .trig_src({trig_ext[4:2], bus_trig, trig_ext[1:0]}),
      .trig_en(cfg_ff.trig_en),
      .start_sel(cfg_ff.start_sel),
      .abort_sel(cfg_ff.abort_sel),
      .low_jitter_mode(cfg_ff.low_jitter_mode),
      .start_pulse(start_pulse),
      .abort_pulse(abort_pulse)
   );

   // Fetch stalls before the FIFO can overflow with one read in flight
   assign fetch_ok = fifo_in_ready && (fifo_level < `TPC_FETCH_LIMIT);
   assign seg_last = (cfg_ff.seg_len == '0) ? '0 : cfg_ff.seg_len - 1'b1;

   // Playback sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_addr = addr_ff;
      nxt_loop = loop_ff;
      nxt_pend = pend_ff;
      nxt_pkind = pkind_ff;
      nxt_first = first_ff;
      seg_rd_en = 1'b0;
      flush = 1'b0;
      unique case (state_ff)
         ST_PRIME: begin
            seg_rd_en = 1'b1; // Read sample 0 for first-sample hold
            nxt_state = ST_CAPT;
         end
         ST_CAPT: begin
            nxt_first = seg_data;
            nxt_state = ST_WAIT;
         end
         ST_WAIT: begin
            if (start_pulse && cfg_ff.run) begin
               nxt_state = ST_PLAY;
               nxt_addr = '0;
               nxt_loop = '0;
               nxt_pend = 1'b0;
               flush = 1'b1; // Drop idle samples still queued
            end else if (seg_chg) begin
               nxt_state = ST_PRIME;
               nxt_addr = '0;
               flush = 1'b1;
            end else if (cfg_ff.idle == IDLE_SEG && fetch_ok) begin
               seg_rd_en = 1'b1;
               nxt_addr = (addr_ff == seg_last) ? '0 : addr_ff + 1'b1;
            end
         end
         ST_PLAY: begin
            if (abort_pulse && cfg_ff.abort_now) begin
               nxt_state = ST_PRIME;
               nxt_addr = '0;
               nxt_pend = 1'b0;
               flush = 1'b1;
            end else if (start_pulse && cfg_ff.abort_now) begin
               nxt_addr = '0;
               nxt_loop = '0;
               nxt_pend = 1'b0;
               flush = 1'b1;
            end else begin
               if ((abort_pulse || start_pulse) && !pend_ff) begin
                  nxt_pend = 1'b1;
                  nxt_pkind = abort_pulse;
               end
               if (fetch_ok) begin
                  seg_rd_en = 1'b1;
                  nxt_addr = addr_ff + 1'b1;
                  if (addr_ff == seg_last) begin
                     nxt_addr = '0;
                     // Act on the pending trigger before clearing it
                     if (nxt_pend && nxt_pkind) begin
                        nxt_state = ST_PRIME;
                     end else if (nxt_pend) begin
                        nxt_loop = '0;
                     end else if (cfg_ff.loops != '0 &&
                                  loop_ff == cfg_ff.loops - 1'b1) begin
                        nxt_state = ST_PRIME;
                     end else begin
                        nxt_loop = loop_ff + 1'b1;
                     end
                     nxt_pend = 1'b0;
                  end
               end
            end
         end
      endcase
      nxt_rdp = seg_rd_en && (state_ff != ST_PRIME);
   end

   // Sequencer registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= ST_PRIME;
         addr_ff <= '0;
         loop_ff <= '0;
         pend_ff <= 1'b0;
         pkind_ff <= 1'b0;
         first_ff <= '0;
         rdp_ff <= 1'b0;
      end else if (ce) begin
         state_ff <= nxt_state;
         addr_ff <= nxt_addr;
         loop_ff <= nxt_loop;
         pend_ff <= nxt_pend;
         pkind_ff <= nxt_pkind;
         first_ff <= nxt_first;
         rdp_ff <= nxt_rdp;
      end
   end

   tpc_fifo #(
      .W(`TPC_DAC_W),
      .DEPTH(`TPC_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .flush(flush),
      .in_valid(rdp_ff),
      .in_ready(fifo_in_ready),
      .in_data(seg_data),
      .out_valid(fifo_ov),
      .out_ready(dac_ready),
      .out_data(fifo_data),
      .level(fifo_level)
   );

   // Output: queued samples first, then the idle level once drained outside ST_PLAY
   always_comb begin
      nxt_dac = dac_ff;
      if (fifo_ov && dac_ready && !flush) begin
         nxt_dac = fifo_data;
      end else if (!fifo_ov && state_ff != ST_PLAY) begin
         unique case (cfg_ff.idle)
            IDLE_DC: nxt_dac = cfg_ff.dc_level;
            IDLE_FIRST: nxt_dac = first_ff;
            IDLE_SEG: nxt_dac = dac_ff;
            default: nxt_dac = cfg_ff.dc_level;
         endcase
      end
   end

   // Output register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dac_ff <= `TPC_RST_DC;
      end else if (ce) begin
         dac_ff <= nxt_dac;
      end
   end
endmodule

/* design/tpc_regs.svh */
// Register offsets, field positions, reset values and sizes of the
// trigger playback control block.
// Assumes word-aligned AHB-Lite access with byte offsets in haddr[7:0].
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// Register byte offsets
`define TPC_OFF_CTRL 8'h00
`define TPC_OFF_SRC 8'h04
`define TPC_OFF_DC 8'h08
`define TPC_OFF_LOOPS 8'h0C
`define TPC_OFF_SEGLEN 8'h10
`define TPC_OFF_STATUS 8'h14

// Control register fields
`define TPC_CTRL_RUN 0
`define TPC_CTRL_NOW 1
`define TPC_CTRL_IDLE_LO 2
`define TPC_CTRL_LJ 4
`define TPC_CTRL_BUSTRIG 5

// Source register fields
`define TPC_SRC_START_LO 0
`define TPC_SRC_ABORT_LO 4
`define TPC_SRC_EN_LO 8

// Status register fields
`define TPC_STAT_STATE_LO 0
`define TPC_STAT_PEND 2
`define TPC_STAT_EMPTY 3
`define TPC_STAT_LOOP_LO 12

// Sizes
`define TPC_DAC_W 16
`define TPC_ADDR_W 16
`define TPC_LOOP_W 20
`define TPC_NSRC 6
`define TPC_FIFO_DEPTH 32
`define TPC_LVL_W 6

// Reset values
`define TPC_RST_DC 16'h0000
`define TPC_RST_LOOPS 20'h00001
`define TPC_RST_SEGLEN 16'h0040

// Timing counts
`define TPC_FETCH_LIMIT 6'h1E
`define TPC_LJ_STAGES 4

`endif

/* design/tpc_trig_qual.sv */
// Trigger gating and source selection for one channel.
// Assumes each source input is a one-cycle valid-trigger pulse.
`timescale 1ns/10ps
`include "tpc_regs.svh"

module tpc_trig_qual
   import tpc_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic [`TPC_NSRC-1:0] trig_src,
   input wire logic [`TPC_NSRC-1:0] trig_en,
   input wire logic [2:0] start_sel,
   input wire logic [2:0] abort_sel,
   input wire logic low_jitter_mode,
   output logic start_pulse,
   output logic abort_pulse
);
   logic [`TPC_NSRC-1:0] gated, hit_start, hit_abort;
   logic [`TPC_LJ_STAGES-1:0] st_line_ff, ab_line_ff;
   logic [`TPC_LJ_STAGES-1:0] nxt_st_line, nxt_ab_line;

   // Per-source gating and selection; code 0 selects nothing
   generate
      for (genvar i = 0; i < `TPC_NSRC; i++) begin : g_src
         assign gated[i] = trig_src[i] & trig_en[i];
         assign hit_start[i] = gated[i] & (start_sel == 3'(i + 1));
         assign hit_abort[i] = gated[i] & (abort_sel == 3'(i + 1));
      end
   endgenerate

   // Fixed-latency delay line; the long tap is the low-jitter path
   always_comb begin
      nxt_st_line = {st_line_ff[`TPC_LJ_STAGES-2:0], |hit_start};
      nxt_ab_line = {ab_line_ff[`TPC_LJ_STAGES-2:0], |hit_abort};
      if (low_jitter_mode) begin
         start_pulse = st_line_ff[`TPC_LJ_STAGES-1];
         abort_pulse = ab_line_ff[`TPC_LJ_STAGES-1];
      end else begin
         start_pulse = st_line_ff[0];
         abort_pulse = ab_line_ff[0];
      end
   end

   // Delay line registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_line_ff <= '0;
         ab_line_ff <= '0;
      end else if (ce) begin
         st_line_ff <= nxt_st_line;
         ab_line_ff <= nxt_ab_line;
      end
   end
endmodule

/* sim/testbench.sv */
// Self-checking bench for tpc_play_ctrl with a segment memory model.
// Assumes the design files, monitor and tpc_seg_mem compile first.
`timescale 1ns/10ps
`include "tpc_regs.svh"
module testbench;
   logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, seg_rd_en;
   logic dac_ready, hit;
   logic [31:0] haddr, hwdata, hrdata, rv, ctrl;
   logic [1:0] htrans;
   logic [4:0] trig_ext;
   logic [15:0] seg_addr, seg_data, dac_data, dcv, seg_end, last;
   int fail_count, checked, ends, lat, l0;
   tpc_play_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .trig_ext(trig_ext), .seg_rd_en(seg_rd_en), .seg_addr(seg_addr),
      .seg_data(seg_data), .dac_ready(dac_ready), .dac_data(dac_data));
   tpc_seg_mem mem (.clk(clk), .rd_en(seg_rd_en), .addr(seg_addr),
      .data(seg_data));
   // Bus helpers
   task automatic wait_rdy();
      do @(posedge clk); while (hreadyout !== 1'b1);
   endtask
   task automatic addr_ph(input logic w, input logic [7:0] a);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge clk);
      addr_ph(w, a);
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rv = hrdata;
   endtask
   task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr_ph(1'b1, a);
      wait_rdy();
      addr_ph(1'b0, a);
      hwdata <= d;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      wait_rdy();
      rv = hrdata;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time,
            seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Setup of one run: control, sources, loops, segment length
   task automatic cfg(input logic [31:0] c, s, n, len);
      ctrl = c;
      seg_end = 16'hA000 + len[15:0] - 16'h0001;
      ahb(1'b1, `TPC_OFF_CTRL, c);
      ahb(1'b1, `TPC_OFF_SRC, s);
      ahb(1'b1, `TPC_OFF_LOOPS, n);
      ahb(1'b1, `TPC_OFF_SEGLEN, len);
   endtask
   // Fire a source by its code; code 3 is the bus trigger
   task automatic trig(input int code);
      if (code == 3) begin
         ahb(1'b1, `TPC_OFF_CTRL, ctrl | 32'h20);
      end else begin
         @(posedge clk);
         trig_ext <= 5'h01 << (code < 3 ? code - 1 : code - 2);
         @(posedge clk);
         trig_ext <= 5'h00;
      end
   endtask
   // Watch the DAC: segment ends, latency, last non-idle sample
   task automatic watch(input int cyc);
      logic [15:0] p;
      p = dac_data;
      ends = 0;
      lat = -1;
      hit = 1'b0;
      for (int i = 0; i < cyc; i++) begin
         @(negedge clk);
         if (dac_data === seg_end && p !== seg_end) ends++;
         if (dac_data !== dcv && lat < 0) lat = i;
         if (dac_data !== dcv) last = dac_data;
         if (dac_data === 16'hA001) hit = 1'b1;
         p = dac_data;
      end
   endtask
   task automatic t_regs();
      ahb(1'b0, `TPC_OFF_LOOPS, 32'h0);
      check(rv, 32'h1);
      ahb(1'b0, `TPC_OFF_SEGLEN, 32'h0);
      check(rv, 32'h40);
      ahb(1'b0, `TPC_OFF_DC, 32'h0);
      check(rv, 32'h0);
      ahb(1'b0, 8'h20, 32'h0);
      check(rv, 32'h0);
      wr_rd(`TPC_OFF_DC, 32'hFFFF1234);
      check({16'h0000, rv[15:0]}, 32'h1234);
      ahb(1'b1, `TPC_OFF_DC, {16'h0000, dcv});
      $display("test regs done");
   endtask
   task automatic t_nostart();
      for (int k = 0; k < 2; k++) begin
         cfg(32'h1, 32'h3F00 | (k * 7), 32'h1, 32'h4);
         for (int s = 1; s < 7; s++) trig(s);
         watch(30);
         check(ends, 0);
         check(dac_data, dcv);
         ahb(1'b0, `TPC_OFF_CTRL, 32'h0);
         check(rv, 32'h1);
      end
      $display("test nostart done");
   endtask
   task automatic t_sources();
      for (int c = 1; c < 7; c++) begin
         cfg(32'h1, 32'h3F00 | c, 32'h1, 32'h4);
         trig(c);
         watch(40);
         check(ends, 1);
         check(dac_data, dcv);
         cfg(32'h1, (32'h3F00 & ~(32'h100 << (c - 1))) | c, 32'h1, 32'h4);
         trig(c);
         watch(30);
         check(ends, 0);
      end
      $display("test sources done");
   endtask
   task automatic t_fifo();
      cfg(32'h1, 32'h3F01, 32'd10, 32'h4);
      dac_ready <= 1'b0;
      trig(1);
      repeat (60) @(negedge clk);
      check(seg_rd_en, 1'b0);
      ahb(1'b0, `TPC_OFF_STATUS, 32'h0);
      check(rv[3], 1'b0);
      dac_ready <= 1'b1;
      watch(200);
      check(ends, 10);
      check(dac_data, dcv);
      ahb(1'b0, `TPC_OFF_STATUS, 32'h0);
      check(rv[3], 1'b1);
      $display("test fifo done");
   endtask
   task automatic t_forever();
      cfg(32'h3, 32'h3F21, 32'h0, 32'h4);
      trig(1);
      watch(60);
      check(ends >= 5, 1'b1);
      trig(2);
      repeat (8) @(negedge clk);
      check(dac_data, dcv);
      watch(30);
      check(ends, 0);
      trig(1);
      watch(40);
      check(ends >= 5, 1'b1);
      trig(2);
      $display("test forever done");
   endtask
   task automatic t_deferred();
      cfg(32'h1, 32'h3F21, 32'h0, 32'd16);
      trig(1);
      watch(10);
      trig(2);
      trig(2);
      watch(80);
      check(last, seg_end);
      check(dac_data, dcv);
      $display("test deferred done");
   endtask
   task automatic t_idle();
      cfg(32'h5, 32'h3F01, 32'h1, 32'h4);
      watch(20);
      check(dac_data, 16'hA000);
      cfg(32'h9, 32'h3F01, 32'h1, 32'h4);
      watch(60);
      check(hit, 1'b1);
      $display("test idle done");
   endtask
   task automatic t_jitter();
      cfg(32'h1, 32'h3F01, 32'h1, 32'h4);
      trig(1);
      watch(30);
      l0 = lat;
      cfg(32'h11, 32'h3F01, 32'h1, 32'h4);
      trig(1);
      watch(30);
      check(lat, l0 + 3);
      $display("test jitter done");
   endtask
   // Clock at 50 MHz
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      trig_ext = 5'h00;
      dac_ready = 1'b1;
      dcv = 16'h5555;
      fail_count = 0;
      checked = 0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_nostart();
      t_sources();
      t_fifo();
      t_forever();
      t_deferred();
      t_idle();
      t_jitter();
      print_verdict();
   end
   // Watchdog well beyond the expected run
   initial begin
      #600000;
      fail_count++;
      print_verdict();
   end
endmodule

/* sim/tpc_play_monitor.sv */
// Checker on the ports of tpc_play_ctrl, bound into every instance.
// Assumes one clock domain and hready looped back from hreadyout.
`timescale 1ns/10ps
`include "tpc_regs.svh"
module tpc_play_monitor (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic seg_rd_en,
   input wire logic [`TPC_ADDR_W-1:0] seg_addr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Bus transfers taken at an edge
   sequence s_rd(logic [7:0] a);
      hsel && htrans[1] && hready && !hwrite && haddr[7:0] == a;
   endsequence
   sequence s_wr(logic [7:0] a);
      hsel && htrans[1] && hready && hwrite && haddr[7:0] == a;
   endsequence
   // Zero wait state slave that never errors
   AST_ZERO_WAIT: assert property (hreadyout && !hresp)
      else $error("slave stalled or gave an error response");
   AST_RD_HOLD: assert property
      (!(hsel && htrans[1] && hready) |=> $stable(hrdata))
      else $error("read data moved without a transfer");
   AST_UNMAPPED: assert property (s_rd(8'h20) |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   AST_CTRL_RD: assert property
      (s_rd(8'h00) |=> hrdata[31:5] == 27'h0)
      else $error("control read shows bus trigger or spare bits");
   AST_DC_RD: assert property (
      s_rd(8'h08) |=> hrdata[31:16] == 16'h0)
      else $error("idle level read wider than sample");
   AST_LOOPS_RD: assert property (
      s_rd(8'h0C) |=> hrdata[31:20] == 12'h0)
      else $error("loop count read wider than field");
   AST_STATUS_RD: assert property
      (s_rd(8'h14) |=> hrdata[11:4] == 8'h0)
      else $error("status spare bits set");
   AST_WR_RD: assert property (
      s_wr(8'h08) ##1 s_rd(8'h08) |=> hrdata[15:0] == $past(hwdata[15:0]))
      else $error("read after write misses new idle level");
   AST_SEG_STEP: assert property (
      seg_rd_en && $past(seg_rd_en)
      |-> seg_addr == 0 || seg_addr == $past(seg_addr) + 1)
      else $error("segment fetch skipped an address");
endmodule
bind tpc_play_ctrl tpc_play_monitor mon (.clk(clk), .sys_rst(sys_rst),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .seg_rd_en(seg_rd_en),
   .seg_addr(seg_addr));

/* sim/tpc_seg_mem.sv */
// Segment memory model: a sample is 0xA000 plus its address.
// Assumes the reader takes data exactly one cycle after its strobe.
`timescale 1ns/10ps
module tpc_seg_mem (
   input wire logic clk,
   input wire logic rd_en,
   input wire logic [15:0] addr,
   output logic [15:0] data
);
   initial data = 16'h0000;
   // Data valid one cycle after the strobe, scrambled otherwise
   always @(posedge clk) begin
      if (rd_en) begin
         data <= 16'hA000 + addr;
      end else begin
         data <= ~data;
      end
   end
endmodule
